// ===== rtl/tmi_host.sv
// host end: drives clock, start and stop, moves bytes to and from the target
`timescale 1ns/1ps
module tmi_host
  import tmi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  tmi_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nacked,
  output logic data_pending
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sy_ff, sda_sy_ff, chg_sy_ff;
  logic scl_s, sda_s;
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      chg_sy_ff <= 2'h3;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], link.scl};
      sda_sy_ff <= {sda_sy_ff[0], link.sda};
      chg_sy_ff <= {chg_sy_ff[0], link.touch_data_pending_n};
    end
  end
  assign scl_s = scl_sy_ff[1];
  assign sda_s = sda_sy_ff[1];
  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  tmi_host_state_t state_ff, nxt_state;
  logic [4:0] tmr_ff, nxt_tmr;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh, left_ff, nxt_left, rd_data_ff, nxt_rd_data;
  logic rd_ff, nxt_rd, is_addr_ff, nxt_is_addr, nacked_ff, nxt_nacked;
  logic scl_oe_n_ff, nxt_scl_oe_n, sda_oe_n_ff, nxt_sda_oe_n;
  logic rd_valid_ff, nxt_rd_valid, done_ff, nxt_done;
  logic cmd_ready_ff, wr_ready_ff, pend_ff;
  logic tx;
  assign tx = is_addr_ff | ~rd_ff;
  // next-state for the whole engine; timing counts run off the local clock
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff + 5'h01;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_rd = rd_ff;
    nxt_is_addr = is_addr_ff;
    nxt_nacked = nacked_ff;
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      TMI_H_IDLE: begin
        nxt_tmr = 5'h00;
        if (cmd_valid && cmd_ready_ff) begin
          nxt_sh = {cmd_addr, cmd_read};
          nxt_rd = cmd_read;
          nxt_left = cmd_len;
          nxt_is_addr = 1'b1;
          nxt_bit = 4'h0;
          nxt_nacked = 1'b0;
          nxt_sda_oe_n = 1'b0;
          nxt_state = TMI_H_START;
        end
      end
      TMI_H_START: begin
        if (tmr_ff == TMI_HALF_LAST) begin
          nxt_scl_oe_n = 1'b0;
          nxt_tmr = 5'h00;
          nxt_state = TMI_H_LO;
        end
      end
      TMI_H_WAIT: begin
        nxt_tmr = 5'h00;
        if (wr_valid && wr_ready_ff) begin
          nxt_sh = wr_data;
          nxt_state = TMI_H_LO;
        end
      end
      TMI_H_LO: begin
        // data changes only while the clock is held low
        if (bit_ff == TMI_BYTE_BITS) begin
          nxt_sda_oe_n = tx | (left_ff == 8'h00);
        end else begin
          nxt_sda_oe_n = tx ? sh_ff[7] : 1'b1;
        end
        if (tmr_ff == TMI_HALF_LAST) begin
          nxt_scl_oe_n = 1'b1;
          nxt_tmr = 5'h00;
          nxt_state = TMI_H_HI;
        end
      end
      TMI_H_HI: begin
        if (!scl_s) begin
          nxt_tmr = 5'h00;
        end else if (tmr_ff == TMI_HALF_LAST) begin
          nxt_scl_oe_n = 1'b0;
          nxt_tmr = 5'h00;
          nxt_state = TMI_H_LO;
          if (bit_ff != TMI_BYTE_BITS) begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == TMI_LAST_BIT && !tx) begin
              nxt_rd_data = {sh_ff[6:0], sda_s};
              nxt_rd_valid = 1'b1;
            end
          end else begin
            // ninth clock: acknowledge slot closes the byte
            nxt_bit = 4'h0;
            if (tx && sda_s) begin
              nxt_nacked = 1'b1;
              nxt_state = TMI_H_STOP_LO;
            end else if (!is_addr_ff && left_ff == 8'h00) begin
              nxt_state = TMI_H_STOP_LO;
            end else begin
              if (!is_addr_ff) begin
                nxt_left = left_ff - 8'h01;
              end
              nxt_is_addr = 1'b0;
              nxt_state = rd_ff ? TMI_H_LO : TMI_H_WAIT;
            end
          end
        end
      end
      TMI_H_STOP_LO: begin
        nxt_sda_oe_n = 1'b0;
        if (tmr_ff == TMI_HALF_LAST) begin
          nxt_scl_oe_n = 1'b1;
          nxt_tmr = 5'h00;
          nxt_state = TMI_H_STOP_HI;
        end
      end
      TMI_H_STOP_HI: begin
        if (!scl_s) begin
          nxt_tmr = 5'h00;
        end else if (tmr_ff == TMI_HALF_LAST) begin
          nxt_sda_oe_n = 1'b1;
          nxt_tmr = 5'h00;
          nxt_state = TMI_H_STOP_END;
        end
      end
      TMI_H_STOP_END: begin
        // bus free time before the next start
        if (tmr_ff == TMI_HALF_LAST) begin
          nxt_done = 1'b1;
          nxt_state = TMI_H_IDLE;
        end
      end
      default: begin
        nxt_state = TMI_H_IDLE;
      end
    endcase
  end
  // registers for the engine and its outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= TMI_H_IDLE;
      tmr_ff <= 5'h00;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      left_ff <= 8'h00;
      rd_ff <= 1'b0;
      is_addr_ff <= 1'b0;
      nacked_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      wr_ready_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      rd_ff <= nxt_rd;
      is_addr_ff <= nxt_is_addr;
      nacked_ff <= nxt_nacked;
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      done_ff <= nxt_done;
      cmd_ready_ff <= (nxt_state == TMI_H_IDLE);
      wr_ready_ff <= (nxt_state == TMI_H_WAIT);
      pend_ff <= ~chg_sy_ff[1];
    end
  end
  // open-drain: only ever pull low or let go
  assign link.scl_h_o = 1'b0;
  assign link.sda_h_o = 1'b0;
  assign link.scl_h_oe_n = scl_oe_n_ff;
  assign link.sda_h_oe_n = sda_oe_n_ff;
  assign cmd_ready = cmd_ready_ff;
  assign wr_ready = wr_ready_ff;
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign done = done_ff;
  assign nacked = nacked_ff;
  assign data_pending = pend_ff;
endmodule

// ===== rtl/tmi_link_if.sv
// two-wire link between host controller and touch target, with pull-ups
`timescale 1ns/1ps
interface tmi_link_if;
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic scl_d_o;
  logic scl_d_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic touch_data_pending_n;
  logic scl;
  logic sda;
  // wired-and: a released line floats high through its pull-up
  assign scl = (scl_h_oe_n | scl_h_o) & (scl_d_oe_n | scl_d_o);
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  modport dev (
    input scl,
    input sda,
    output scl_d_o,
    output scl_d_oe_n,
    output sda_d_o,
    output sda_d_oe_n,
    output touch_data_pending_n
  );
  modport host (
    input scl,
    input sda,
    input touch_data_pending_n,
    output scl_h_o,
    output scl_h_oe_n,
    output sda_h_o,
    output sda_h_oe_n
  );
endinterface

// ===== rtl/tmi_pkg.sv
// shared constants and state types for the touch module two-wire link
package tmi_pkg;
  // ----------------------------------------
  // addressing and byte framing
  // ----------------------------------------
  localparam logic [6:0] TMI_DEV_ADDR = 7'h4A;
  localparam logic [3:0] TMI_BYTE_BITS = 4'h8;
  localparam logic [3:0] TMI_LAST_BIT = 4'h7;
  // ----------------------------------------
  // timing: local clock and bus clock ceiling
  // ----------------------------------------
  localparam int TMI_CLK_HZ = 10000000;
  localparam int TMI_SCL_MAX_HZ = 400000;
  // half bus period rounded up so the bus never exceeds its ceiling
  localparam int TMI_HALF_CYC = (TMI_CLK_HZ + 2 * TMI_SCL_MAX_HZ - 1) / (2 * TMI_SCL_MAX_HZ);
  localparam logic [4:0] TMI_HALF_LAST = 5'(TMI_HALF_CYC - 1);
  // ----------------------------------------
  // state encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    TMI_D_IDLE = 3'h0,
    TMI_D_ADDR = 3'h1,
    TMI_D_ADDR_ACK = 3'h2,
    TMI_D_LOAD = 3'h3,
    TMI_D_RD_BYTE = 3'h4,
    TMI_D_RD_ACK = 3'h5,
    TMI_D_WR_BYTE = 3'h6,
    TMI_D_WR_WAIT = 3'h7
  } tmi_dev_state_t;
  typedef enum logic [2:0] {
    TMI_H_IDLE = 3'h0,
    TMI_H_START = 3'h1,
    TMI_H_LO = 3'h2,
    TMI_H_HI = 3'h3,
    TMI_H_WAIT = 3'h4,
    TMI_H_STOP_LO = 3'h5,
    TMI_H_STOP_HI = 3'h6,
    TMI_H_STOP_END = 3'h7
  } tmi_host_state_t;
endpackage

// ===== rtl/tmi_target.sv
// touch module target end: address match, byte transfer, clock stretching
`timescale 1ns/1ps
module tmi_target
  import tmi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  tmi_link_if.dev link,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic new_data_evt,
  output logic bus_busy
);
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic scl_d_ff, sda_d_ff;
  logic scl_s, sda_s, scl_rise, scl_fall, start, stop;
  // edge detect looks only at the second stage and its delayed copy
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], link.scl};
      sda_sy_ff <= {sda_sy_ff[0], link.sda};
      scl_d_ff <= scl_sy_ff[1];
      sda_d_ff <= sda_sy_ff[1];
    end
  end
  assign scl_s = scl_sy_ff[1];
  assign sda_s = sda_sy_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  // conditions: data line moves while the clock sits high
  assign start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  // ----------------------------------------
  // address match
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] b);
    return b[7:1] == TMI_DEV_ADDR;
  endfunction
  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  tmi_dev_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, rx_data_ff, nxt_rx_data;
  logic rw_ff, nxt_rw, sda_oe_n_ff, nxt_sda_oe_n;
  logic busy_ff, nxt_busy, sess_rd_ff, nxt_sess_rd, pend_ff, nxt_pend;
  logic scl_oe_n_ff, tx_ready_ff, rx_valid_ff, pend_n_ff;
  // bits are sampled on rising clock, driven after falling clock
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_busy = busy_ff;
    nxt_sess_rd = sess_rd_ff;
    case (state_ff)
      TMI_D_IDLE: begin
        nxt_sda_oe_n = 1'b1;
      end
      TMI_D_ADDR: begin
        if (scl_rise) begin
          nxt_sh = {sh_ff[6:0], sda_s};
          nxt_cnt = cnt_ff + 4'h1;
        end else if (scl_fall && cnt_ff == TMI_BYTE_BITS) begin
          if (addr_hit(sh_ff)) begin
            nxt_sda_oe_n = 1'b0;
            nxt_rw = sh_ff[0];
            nxt_sess_rd = sh_ff[0];
            nxt_state = TMI_D_ADDR_ACK;
          end else begin
            nxt_state = TMI_D_IDLE;
          end
        end
      end
      TMI_D_ADDR_ACK: begin
        if (scl_fall) begin
          nxt_sda_oe_n = 1'b1;
          nxt_cnt = 4'h0;
          nxt_state = rw_ff ? TMI_D_LOAD : TMI_D_WR_BYTE;
        end
      end
      TMI_D_LOAD: begin
        // clock stays stretched until the touch core offers a byte
        if (tx_valid && tx_ready_ff) begin
          nxt_sh = tx_data;
          nxt_sda_oe_n = tx_data[7];
          nxt_cnt = 4'h0;
          nxt_state = TMI_D_RD_BYTE;
        end
      end
      TMI_D_RD_BYTE: begin
        if (scl_fall) begin
          if (cnt_ff == TMI_LAST_BIT) begin
            nxt_sda_oe_n = 1'b1;
            nxt_state = TMI_D_RD_ACK;
          end else begin
            nxt_sda_oe_n = sh_ff[6];
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
      TMI_D_RD_ACK: begin
        // a high acknowledge from the host ends the read stream
        if (scl_rise) begin
          nxt_sh[0] = sda_s;
        end else if (scl_fall) begin
          nxt_state = sh_ff[0] ? TMI_D_IDLE : TMI_D_LOAD;
        end
      end
      TMI_D_WR_BYTE: begin
        if (scl_rise) begin
          nxt_sh = {sh_ff[6:0], sda_s};
          nxt_cnt = cnt_ff + 4'h1;
        end else if (scl_fall && cnt_ff == TMI_BYTE_BITS) begin
          nxt_rx_data = sh_ff;
          nxt_state = TMI_D_WR_WAIT;
        end
      end
      TMI_D_WR_WAIT: begin
        // no buffer: the ninth clock waits until the user takes the byte
        if (rx_valid_ff && rx_ready) begin
          nxt_sda_oe_n = 1'b0;
          // one below zero: the ack clock's rise wraps the count back to zero
          nxt_cnt = 4'hF;
          nxt_state = TMI_D_WR_BYTE;
        end
      end
      default: begin
        nxt_state = TMI_D_IDLE;
      end
    endcase
    // acknowledge on a write byte is released at the ninth falling clock
    if (state_ff == TMI_D_WR_BYTE && scl_fall && cnt_ff == 4'h0) begin
      nxt_sda_oe_n = 1'b1;
    end
    // start and stop override any byte in flight
    if (start) begin
      nxt_state = TMI_D_ADDR;
      nxt_cnt = 4'h0;
      nxt_busy = 1'b1;
      nxt_sda_oe_n = 1'b1;
      nxt_sess_rd = 1'b0;
    end else if (stop) begin
      nxt_state = TMI_D_IDLE;
      nxt_busy = 1'b0;
      nxt_sda_oe_n = 1'b1;
      nxt_sess_rd = 1'b0;
    end
    // new data wins over the clear from a finished read
    nxt_pend = new_data_evt | (pend_ff & ~(stop & sess_rd_ff));
  end
  // registers for the engine and its outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= TMI_D_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rx_data_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      busy_ff <= 1'b0;
      sess_rd_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_n_ff <= 1'b1;
      scl_oe_n_ff <= 1'b1;
      tx_ready_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rx_data_ff <= nxt_rx_data;
      rw_ff <= nxt_rw;
      sda_oe_n_ff <= nxt_sda_oe_n;
      busy_ff <= nxt_busy;
      sess_rd_ff <= nxt_sess_rd;
      pend_ff <= nxt_pend;
      pend_n_ff <= ~nxt_pend;
      scl_oe_n_ff <= ~(nxt_state == TMI_D_LOAD || nxt_state == TMI_D_WR_WAIT);
      tx_ready_ff <= (nxt_state == TMI_D_LOAD);
      rx_valid_ff <= (nxt_state == TMI_D_WR_WAIT);
    end
  end
  // open-drain drivers; the interrupt line is low while data waits
  assign link.scl_d_o = 1'b0;
  assign link.sda_d_o = 1'b0;
  assign link.scl_d_oe_n = scl_oe_n_ff;
  assign link.sda_d_oe_n = sda_oe_n_ff;
  assign link.touch_data_pending_n = pend_n_ff;
  assign tx_ready = tx_ready_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign bus_busy = busy_ff;
endmodule

// ===== testbench/testbench.sv
// self-checking bench: host and touch target joined over the two-wire link
`timescale 1ns/1ps
module testbench
  import tmi_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'h0;
  logic rx_ready = 1'h0;
  logic new_data_evt = 1'h0;
  logic cmd_ready, wr_ready, rd_valid, done, nacked, data_pending;
  logic tx_ready, rx_valid, bus_busy;
  logic [7:0] rd_data, rx_data;
  logic [6:0] far [3] = '{7'h4B, 7'h0A, 7'h25};
  int err_count = 0;
  int cmp_count = 0;
  tmi_link_if i_tmi_link_if();
  tmi_host i_tmi_host(.clk(clk), .rst(rst), .link(i_tmi_link_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nacked(nacked), .data_pending(data_pending));
  tmi_target i_tmi_target(.clk(clk), .rst(rst), .link(i_tmi_link_if), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .new_data_evt(new_data_evt), .bus_busy(bus_busy));
  tmi_link_checker i_tmi_link_checker(.clk(clk), .rst(rst),
    .scl_h_o(i_tmi_link_if.scl_h_o), .sda_h_o(i_tmi_link_if.sda_h_o),
    .scl_d_o(i_tmi_link_if.scl_d_o), .sda_d_o(i_tmi_link_if.sda_d_o),
    .scl_d_oe_n(i_tmi_link_if.scl_d_oe_n), .sda_d_oe_n(i_tmi_link_if.sda_d_oe_n),
    .scl(i_tmi_link_if.scl), .sda(i_tmi_link_if.sda));
  // ----------------------------------------
  // compare and transfer tasks
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end
    else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one command; both user sides served each low phase, rx side stalls
  task automatic xfer(input logic rd, input logic [6:0] addr, input int n,
    input logic [7:0] base);
    int wi = 0;
    int ti = 0;
    int ri = 0;
    int ki = 0;
    int stall = 0;
    logic tw = 1'h0;
    logic tt = 1'h0;
    logic tr = 1'h0;
    logic seen = 1'h0;
    logic fin = 1'h0;
    logic ok;
    ok = (addr == TMI_DEV_ADDR);
    while (cmd_ready !== 1'h1) @(negedge clk);
    cmd_read = rd;
    cmd_addr = addr;
    cmd_len = 8'(n - 1);
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    while (!fin) begin
      @(negedge clk);
      seen |= (bus_busy === 1'h1);
      if (tw) begin
        wi++;
        wr_valid = 1'h0;
      end else if (wr_ready === 1'h1 && wi < n) begin
        wr_data = base + 8'(wi);
        wr_valid = 1'h1;
      end
      if (tt) begin
        ti++;
        tx_valid = 1'h0;
      end else if (tx_ready === 1'h1 && ti < n) begin
        tx_data = base + 8'(ti);
        tx_valid = 1'h1;
      end
      if (tr) begin
        ri++;
        rx_ready = 1'h0;
      end else if (rx_valid === 1'h1 && ++stall == 3) begin
        chk_byte(rx_data, base + 8'(ri));
        rx_ready = 1'h1;
        stall = 0;
      end
      if (rd_valid === 1'h1) begin
        chk_byte(rd_data, base + 8'(ki));
        ki++;
      end
      tw = wr_valid & wr_ready;
      tt = tx_valid & tx_ready;
      tr = rx_valid & rx_ready;
      fin = (done === 1'h1);
    end
    chk_bit(nacked, !ok);
    chk_byte(8'(rd ? ki : ri), ok ? 8'(n) : 8'h00);
    chk_bit(seen, 1'h1);
    chk_bit(bus_busy, 1'h0);
    $display("test end: rd %0d addr %h bytes %0d", rd, addr, n);
  endtask
  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  // far addresses differ in one low bit, the top bit, and by a shift
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    new_data_evt = 1'h1;
    @(negedge clk);
    new_data_evt = 1'h0;
    repeat (5) @(negedge clk);
    chk_bit(i_tmi_link_if.touch_data_pending_n, 1'h0);
    chk_bit(data_pending, 1'h1);
    xfer(1'h0, TMI_DEV_ADDR, 3, 8'hA5);
    chk_bit(data_pending, 1'h1);
    xfer(1'h1, TMI_DEV_ADDR, 2, 8'h3C);
    repeat (5) @(negedge clk);
    chk_bit(data_pending, 1'h0);
    foreach (far[i]) begin
      xfer(1'h0, far[i], 1, 8'h00);
      xfer(1'h1, far[i], 1, 8'h00);
    end
    xfer(1'h0, TMI_DEV_ADDR, 1, 8'hFF);
    xfer(1'h1, TMI_DEV_ADDR, 1, 8'h80);
    close_out();
  end
  // all transfers together need well under a quarter of this span
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule

// ===== testbench/tmi_link_checker.sv
// concurrent checks on the two-wire link between host and touch target
`timescale 1ns/1ps
module tmi_link_checker
  import tmi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_h_o,
  input wire logic sda_h_o,
  input wire logic scl_d_o,
  input wire logic sda_d_o,
  input wire logic scl_d_oe_n,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // bus decoder
  // ----------------------------------------
  localparam int MIN_PER = TMI_CLK_HZ / TMI_SCL_MAX_HZ;
  logic scl_ff, sda_ff, first_ff, rw_ff, hit_ff;
  logic nxt_first, nxt_rw, nxt_hit;
  logic [3:0] bit_ff, nxt_bit;
  logic [6:0] sh_ff, nxt_sh;
  logic [7:0] per_ff, nxt_per;
  logic rise, start, stop;
  // next values; period counter saturates so idle gaps never wrap
  always_comb begin
    rise = scl & ~scl_ff;
    start = scl & scl_ff & sda_ff & ~sda;
    stop = scl & scl_ff & ~sda_ff & sda;
    nxt_first = first_ff;
    nxt_rw = rw_ff;
    nxt_hit = hit_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_per = per_ff + {7'h00, per_ff != 8'hFF};
    if (rise) begin
      nxt_per = 8'h00;
      nxt_bit = (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      nxt_sh = {sh_ff[5:0], sda};
      nxt_first = first_ff & (bit_ff != 4'h8);
      if (first_ff && bit_ff == 4'h7) begin
        nxt_rw = sda;
        nxt_hit = (sh_ff == TMI_DEV_ADDR);
      end
    end
    if (start | stop) begin
      nxt_first = start;
      nxt_bit = 4'h0;
      nxt_hit = 1'h0;
    end
  end
  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_ff <= 1'h1;
      sda_ff <= 1'h1;
      first_ff <= 1'h0;
      rw_ff <= 1'h0;
      hit_ff <= 1'h0;
      bit_ff <= 4'h0;
      sh_ff <= 7'h00;
      per_ff <= 8'hFF;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      first_ff <= nxt_first;
      rw_ff <= nxt_rw;
      hit_ff <= nxt_hit;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      per_ff <= nxt_per;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_open_drain;
    !(scl_h_o | sda_h_o | scl_d_o | sda_d_o);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("a driver offers a high level");
  property p_sda_steady;
    scl && $past(scl) |-> $stable(sda_d_oe_n);
  endproperty
  a_sda_steady: assert property (p_sda_steady)
    else $error("target moved data while clock high");
  property p_stretch_low;
    $fell(scl_d_oe_n) |-> !$past(scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("target pulled a high clock low");
  property p_addr_ack;
    rise && first_ff && bit_ff == 4'h8 && hit_ff |-> !sda_d_oe_n && !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_foreign;
    rise && first_ff && bit_ff == 4'h8 && !hit_ff |-> sda_d_oe_n;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign address acknowledged");
  property p_wr_ack;
    rise && !first_ff && hit_ff && !rw_ff && bit_ff == 4'h8 |-> !sda_d_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write byte not acknowledged");
  property p_rd_release;
    rise && !first_ff && hit_ff && rw_ff && bit_ff == 4'h8 |-> sda_d_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("target held data in host ack slot");
  property p_wr_quiet;
    rise && !first_ff && hit_ff && !rw_ff && bit_ff != 4'h8 |-> sda_d_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("target drove data during a write");
  property p_scl_rate;
    rise |-> per_ff >= 8'(MIN_PER - 1);
  endproperty
  a_scl_rate: assert property (p_scl_rate)
    else $error("bus clock period too short");
endmodule
